/* File: rtl/dbg_defs.svh */
`ifndef DBG_DEFS_SVH
`define DBG_DEFS_SVH

// ==========================================================
// Device register indices (nine-byte window plus reset reg)
`define IDX_CMP_A_HIGH 4'h0
`define IDX_CMP_A_LOW 4'h1
`define IDX_CMP_B_HIGH 4'h2
`define IDX_CMP_B_LOW 4'h3
`define IDX_TRACE_HIGH 4'h4
`define IDX_TRACE_LOW 4'h5
`define IDX_CONTROL 4'h6
`define IDX_FORCE_RESET 4'h9

// ==========================================================
// Control register bits
`define CTL_ENABLE 7
`define CTL_ARM 6
`define CTL_TAG 5
`define CTL_BREAK_EN 4
`define CTL_DIR_A 3
`define CTL_DIR_A_EN 2
`define CTL_DIR_B 1
`define CTL_DIR_B_EN 0
`define FORCE_RESET_BIT 0

// ==========================================================
// Trace buffer and trigger modes
`define TRACE_DEPTH 8
`define FILL_FULL 4'h8
`define FILL_ONE 4'h1
`define FILL_EMPTY 4'h0
`define BYTE_ZERO 8'h00
`define MODE_A_ONLY 4'h0
`define MODE_EVENT_B 4'h3
`define MODE_A_THEN_EVENT_B 4'h4

// ==========================================================
// Host APB register map and fields
`define APB_CMD 12'h000
`define APB_STATUS 12'h004
`define CMD_DATA_LSB 0
`define CMD_IDX_LSB 8
`define CMD_WRITE_BIT 16
`define CMD_SERIAL_BIT 17
`define STS_BUSY_BIT 0
`define STS_DATA_LSB 8

`endif

/* File: rtl/dbg_pkg.sv */
`include "dbg_defs.svh"

package dbg_pkg;

  typedef logic [15:0] trace_word_type;

  typedef struct packed {
    logic [15:0] cmp_a;
    logic [15:0] cmp_b;
    logic [7:0] control;
    trace_word_type [`TRACE_DEPTH-1:0] trace;
    logic [3:0] fill;
    logic triggered;
    logic [15:0] last_opcode;
    logic [7:0] rdata;
    logic ack;
    logic break_force;
    logic break_tag;
    logic reset_req;
  } device_state_type;

  typedef enum logic [0:0] {HOST_IDLE, HOST_WAIT} host_phase_type;

  typedef struct packed {
    host_phase_type phase;
    logic [3:0] idx;
    logic [7:0] wdata;
    logic wr;
    logic rd;
    logic serial;
    logic busy;
    logic [7:0] rdata;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
  } host_state_type;

endpackage

/* File: rtl/dbg_link_if.sv */
interface dbg_link_if;
  logic [3:0] idx;
  logic [7:0] wdata;
  logic wr;
  logic rd;
  logic serial;
  logic [7:0] rdata;
  logic ack;

  modport device (
    input idx, wdata, wr, rd, serial,
    output rdata, ack
  );

  modport host (
    output idx, wdata, wr, rd, serial,
    input rdata, ack
  );
endinterface

/* File: rtl/dbg_comparator.sv */
module dbg_comparator (
  input wire logic [15:0] compare, // Compare value
  input wire logic [15:0] addr, // CPU address
  input wire logic valid, // CPU cycle valid
  input wire logic cpu_read, // 1 read, 0 write
  input wire logic dir_enable, // Qualify by direction
  input wire logic dir, // 1 match reads only
  output logic match // Qualified match
);
  always_comb begin
    match = valid && (addr == compare) &&
            (!dir_enable || (cpu_read == dir));
  end
endmodule // dbg_comparator

/* File: rtl/dbg_device.sv */
// Overview of operation
// - User writes ignored; forced-reset reads zero.
// - Serial write of bit0 forces reset.
// - Comparator bytes reset zero, locked while armed.
// - Each comparator built from high/low bytes.
// - Trace high read-only; zero in event modes.
// - Trace high read keeps read position.
// - Trace low read advances; read high first.
// - Event modes store bytes, read low only.
// - Armed low reads do not advance buffer.
// - Unarmed low read stores last opcode address.
// - Host discards eight reads to prime profiling.
// - Nine-byte register window for application access.
// - Control register accessible regardless of arm.
// - Bit7 enables; refused while secure.
// - Bit6 arms; run end or clear stops.
// - Bit5 picks tag or force break.
// - Bit4 breaks on trigger or full buffer.
// - Trigger type never changes break timing.
// - Bits 2/3 qualify comparator A direction.
// - Bits 0/1 qualify comparator B direction.
// - Run ends on full or trigger; arm clears.
// - Modes 0011 and 0100 are event-only.
`include "dbg_defs.svh"

module dbg_device
  import dbg_pkg::*;
(
  input wire logic pclk, // Bus clock
  input wire logic presetn, // Async reset, active low
  input wire logic ce, // Clock enable
  dbg_link_if.device link, // Register access port
  input wire logic cpu_valid, // CPU bus cycle valid
  input wire logic cpu_read, // CPU cycle is a read
  input wire logic cpu_opfetch, // CPU cycle is opcode fetch
  input wire logic [15:0] cpu_addr, // CPU address
  input wire logic [7:0] cpu_data, // CPU data byte
  input wire logic secure, // MCU secure state
  input wire logic [3:0] trigger_mode_field, // Trigger mode
  input wire logic begin_trace, // 1 begin, 0 end trace
  output logic break_force, // Force-type break pulse
  output logic break_tag, // Tag-type break pulse
  output logic mcu_reset_req, // Full reset request pulse
  output logic armed_flag // Run in progress
);
  import dbg_pkg::*;

  // ==========================================================
  // Helpers
  function automatic trace_word_type [`TRACE_DEPTH-1:0] shift_in(
      input trace_word_type [`TRACE_DEPTH-1:0] t,
      input trace_word_type w);
    trace_word_type [`TRACE_DEPTH-1:0] r;
    r = t;
    for (int i = 0; i < `TRACE_DEPTH - 1; i++) begin
      r[i] = t[i+1];
    end
    r[`TRACE_DEPTH-1] = w;
    return r;
  endfunction

  function automatic logic is_event_mode(input logic [3:0] m);
    return (m == `MODE_EVENT_B) ||
           (m == `MODE_A_THEN_EVENT_B);
  endfunction

  // ==========================================================
  // State
  device_state_type s_r;
  device_state_type s_nxt;
  logic match_a;
  logic match_b;
  logic armed;
  logic event_mode;
  logic trig;
  logic run_done;
  logic [7:0] ctl;

  assign armed = s_r.control[`CTL_ARM];
  assign event_mode = is_event_mode(trigger_mode_field);

  // ==========================================================
  // Comparators
  dbg_comparator cmp_a_inst (
    .compare(s_r.cmp_a),
    .addr(cpu_addr),
    .valid(cpu_valid),
    .cpu_read(cpu_read),
    .dir_enable(s_r.control[`CTL_DIR_A_EN]),
    .dir(s_r.control[`CTL_DIR_A]),
    .match(match_a)
  );

  dbg_comparator cmp_b_inst (
    .compare(s_r.cmp_b),
    .addr(cpu_addr),
    .valid(cpu_valid),
    .cpu_read(cpu_read),
    .dir_enable(s_r.control[`CTL_DIR_B_EN]),
    .dir(s_r.control[`CTL_DIR_B]),
    .match(match_b)
  );

  // ==========================================================
  // Next state
  always_comb begin
    s_nxt = s_r;
    ctl = s_r.control;
    s_nxt.ack = 1'b0;
    s_nxt.break_force = 1'b0;
    s_nxt.break_tag = 1'b0;
    s_nxt.reset_req = 1'b0;
    run_done = 1'b0;
    trig = (trigger_mode_field == `MODE_A_ONLY) ? match_a :
           (match_a || match_b);

    if (cpu_valid && cpu_opfetch) begin
      s_nxt.last_opcode = cpu_addr;
    end

    // Capture while armed
    if (armed && cpu_valid) begin
      if (event_mode) begin
        // Event modes always behave as begin traces
        if (match_b) begin
          s_nxt.trace = shift_in(s_r.trace,
                                 {`BYTE_ZERO, cpu_data});
          s_nxt.fill = s_r.fill + `FILL_ONE;
          run_done = (s_nxt.fill == `FILL_FULL);
        end
      end else if (begin_trace) begin
        if (s_r.triggered || trig) begin
          s_nxt.triggered = 1'b1;
          s_nxt.trace = shift_in(s_r.trace, cpu_addr);
          s_nxt.fill = s_r.fill + `FILL_ONE;
          run_done = (s_nxt.fill == `FILL_FULL);
        end
      end else begin
        // End trace fills circularly until the trigger
        s_nxt.trace = shift_in(s_r.trace, cpu_addr);
        if (s_r.fill != `FILL_FULL) begin
          s_nxt.fill = s_r.fill + `FILL_ONE;
        end
        run_done = trig;
      end
    end

    // Break timing depends only on run end, not trigger type
    if (run_done) begin
      s_nxt.control[`CTL_ARM] = 1'b0;
      if (s_r.control[`CTL_BREAK_EN]) begin
        s_nxt.break_tag = s_r.control[`CTL_TAG];
        s_nxt.break_force = !s_r.control[`CTL_TAG];
      end
    end

    // Register reads (window is ordinary application space)
    if (link.rd) begin
      s_nxt.ack = 1'b1;
      unique case (link.idx)
        `IDX_CMP_A_HIGH: s_nxt.rdata = s_r.cmp_a[15:8];
        `IDX_CMP_A_LOW: s_nxt.rdata = s_r.cmp_a[7:0];
        `IDX_CMP_B_HIGH: s_nxt.rdata = s_r.cmp_b[15:8];
        `IDX_CMP_B_LOW: s_nxt.rdata = s_r.cmp_b[7:0];
        `IDX_TRACE_HIGH: begin
          // No shift here, so a high/low pair stays aligned
          s_nxt.rdata = event_mode ? `BYTE_ZERO :
                        s_r.trace[0][15:8];
        end
        `IDX_TRACE_LOW: begin
          s_nxt.rdata = s_r.trace[0][7:0];
          if (!armed) begin
            s_nxt.trace = shift_in(s_r.trace,
                                   s_r.last_opcode);
          end
        end
        `IDX_CONTROL: s_nxt.rdata = s_r.control;
        default: s_nxt.rdata = `BYTE_ZERO;
      endcase
    end

    // Register writes
    if (link.wr) begin
      s_nxt.ack = 1'b1;
      unique case (link.idx)
        `IDX_CMP_A_HIGH: begin
          if (!armed) s_nxt.cmp_a[15:8] = link.wdata;
        end
        `IDX_CMP_A_LOW: begin
          if (!armed) s_nxt.cmp_a[7:0] = link.wdata;
        end
        `IDX_CMP_B_HIGH: begin
          if (!armed) s_nxt.cmp_b[15:8] = link.wdata;
        end
        `IDX_CMP_B_LOW: begin
          if (!armed) s_nxt.cmp_b[7:0] = link.wdata;
        end
        `IDX_CONTROL: begin
          ctl = link.wdata;
          ctl[`CTL_ENABLE] = link.wdata[`CTL_ENABLE] &&
              (!secure || s_r.control[`CTL_ENABLE]);
          if (!ctl[`CTL_ENABLE]) begin
            ctl[`CTL_ARM] = 1'b0;
          end
          if (ctl[`CTL_ARM] && !armed) begin
            // Fresh run starts with empty count
            s_nxt.fill = `FILL_EMPTY;
            s_nxt.triggered = 1'b0;
          end
          s_nxt.control = ctl;
        end
        `IDX_FORCE_RESET: begin
          // Application writes never reach the reset
          if (link.serial &&
              link.wdata[`FORCE_RESET_BIT]) begin
            s_nxt.reset_req = 1'b1;
          end
        end
        default: begin
          // Trace ports and other bytes ignore writes
          s_nxt.ack = 1'b1;
        end
      endcase
    end
  end

  // ==========================================================
  // Registers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s_r <= '0;
    end else if (ce) begin
      s_r <= s_nxt;
    end
  end

  assign link.rdata = s_r.rdata;
  assign link.ack = s_r.ack;
  assign break_force = s_r.break_force;
  assign break_tag = s_r.break_tag;
  assign mcu_reset_req = s_r.reset_req;
  assign armed_flag = s_r.control[`CTL_ARM];
endmodule // dbg_device

/* File: rtl/dbg_host.sv */
`include "dbg_defs.svh"

module dbg_host
  import dbg_pkg::*;
(
  input wire logic pclk, // Bus clock
  input wire logic presetn, // Async reset, active low
  input wire logic ce, // Clock enable
  input wire logic psel, // APB select
  input wire logic penable, // APB enable
  input wire logic pwrite, // APB direction
  input wire logic [11:0] paddr, // APB address
  input wire logic [31:0] pwdata, // APB write data
  output logic [31:0] prdata, // APB read data
  output logic pready, // APB ready
  output logic pslverr, // APB error, unmapped
  dbg_link_if.host link // Device register port
);
  import dbg_pkg::*;

  // ==========================================================
  // State
  host_state_type s_r;
  host_state_type s_nxt;
  logic setup;
  logic take;

  assign setup = psel && !penable;
  assign take = psel && penable && s_r.pready;

  always_comb begin
    s_nxt = s_r;
    s_nxt.wr = 1'b0;
    s_nxt.rd = 1'b0;
    s_nxt.pready = setup;
    s_nxt.pslverr = 1'b0;
    if (setup) begin
      s_nxt.pslverr = (paddr != `APB_CMD) && (paddr != `APB_STATUS);
      s_nxt.prdata = 32'h0;
      if (!pwrite && paddr == `APB_STATUS) begin
        s_nxt.prdata[`STS_BUSY_BIT] = s_r.busy;
        s_nxt.prdata[`STS_DATA_LSB +: 8] = s_r.rdata;
      end
    end

    unique case (s_r.phase)
      HOST_IDLE: begin
        // Commands while busy are dropped; poll busy first
        if (take && pwrite && paddr == `APB_CMD) begin
          s_nxt.idx = pwdata[`CMD_IDX_LSB +: 4];
          s_nxt.wdata = pwdata[`CMD_DATA_LSB +: 8];
          s_nxt.serial = pwdata[`CMD_SERIAL_BIT];
          s_nxt.wr = pwdata[`CMD_WRITE_BIT];
          s_nxt.rd = !pwdata[`CMD_WRITE_BIT];
          s_nxt.busy = 1'b1;
          s_nxt.phase = HOST_WAIT;
        end
      end
      HOST_WAIT: begin
        if (link.ack) begin
          s_nxt.rdata = link.rdata;
          s_nxt.busy = 1'b0;
          s_nxt.phase = HOST_IDLE;
        end
      end
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s_r <= '0;
    end else if (ce) begin
      s_r <= s_nxt;
    end
  end

  assign prdata = s_r.prdata;
  assign pready = s_r.pready;
  assign pslverr = s_r.pslverr;
  assign link.idx = s_r.idx;
  assign link.wdata = s_r.wdata;
  assign link.wr = s_r.wr;
  assign link.rd = s_r.rd;
  assign link.serial = s_r.serial;
endmodule // dbg_host

/* File: tb/dbg_checker.sv */
module dbg_checker (
  input wire logic pclk, // Bus clock
  input wire logic presetn, // Reset, active low
  input wire logic [3:0] idx, // Link index
  input wire logic [7:0] wdata, // Link write data
  input wire logic wr, // Link write strobe
  input wire logic rd, // Link read strobe
  input wire logic serial, // Serial command
  input wire logic [7:0] rdata, // Link read data
  input wire logic ack, // Link answer
  input wire logic [3:0] trigger_mode_field, // Trigger mode
  input wire logic armed_flag, // Run in progress
  input wire logic break_force, // Force break
  input wire logic break_tag, // Tag break
  input wire logic mcu_reset_req // Reset request
);
  timeunit 1ns;
  timeprecision 1ns;
  // ==========================================================
  // Sequences
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  sequence s_req;
    wr || rd;
  endsequence
  sequence s_ans;
    ack ##1 !ack;
  endsequence
  sequence s_frst;
    wr && serial && idx == 4'h9 && wdata[0];
  endsequence
  // ==========================================================
  // Properties
  AST_LINK_ACK: assert property (s_req |=> s_ans)
    else $error("link request not answered once");
  AST_FORCE_RESET: assert property (s_frst |=> mcu_reset_req)
    else $error("serial reset write gave no reset");
  AST_USER_NO_RESET: assert property (
    wr && !serial && idx == 4'h9 |=> !mcu_reset_req)
    else $error("user write caused a reset");
  AST_RESET_CAUSE: assert property (
    mcu_reset_req |-> $past(wr) && $past(serial) && $past(idx) == 4'h9 &&
    $past(wdata[0]))
    else $error("reset request without cause");
  AST_RESET_READ_ZERO: assert property (
    rd && idx == 4'h9 |=> rdata == 8'h00)
    else $error("reset register read not zero");
  AST_TRACE_HIGH_EVENT: assert property (
    rd && idx == 4'h4 && trigger_mode_field inside {4'h3, 4'h4}
    |=> rdata == 8'h00)
    else $error("trace high not zero in event mode");
  AST_ONE_BREAK: assert property (!(break_tag && break_force))
    else $error("both break kinds at once");
  AST_BREAK_ENDS_RUN: assert property (
    break_tag || break_force |-> $fell(armed_flag))
    else $error("break without end of run");
  AST_DISARM: assert property (
    wr && idx == 4'h6 && !wdata[6] |=> !armed_flag)
    else $error("run not stopped by arm clear");
  AST_ARM_BY_WRITE: assert property (
    $rose(armed_flag) |-> $past(wr) && $past(idx) == 4'h6 &&
    $past(wdata[6]))
    else $error("arm flag rose without write");
endmodule // dbg_checker

/* File: tb/debug_compare_trace_regs_tb.sv */
module debug_compare_trace_regs_tb;
  timeunit 1ns;
  timeprecision 1ns;
  import dbg_pkg::*;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, e;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, r;
  logic cpu_valid, cpu_read, cpu_opfetch, secure, begin_trace;
  logic [15:0] cpu_addr;
  logic [7:0] cpu_data, n_rst, n_tag, n_force, q;
  logic [3:0] trigger_mode_field;
  logic break_force, break_tag, mcu_reset_req, armed_flag;
  logic [7:0] cv [4] = '{8'h20, 8'h40, 8'h30, 8'h50};
  int n_fail, checked;
  dbg_link_if link ();
  dbg_host i_dbg_host (.pclk(pclk), .presetn(presetn), .ce(1'b1),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .link(link.host));
  dbg_device i_dbg_device (.pclk(pclk), .presetn(presetn), .ce(1'b1),
    .link(link.device), .cpu_valid(cpu_valid), .cpu_read(cpu_read),
    .cpu_opfetch(cpu_opfetch), .cpu_addr(cpu_addr),
    .cpu_data(cpu_data), .secure(secure),
    .trigger_mode_field(trigger_mode_field), .begin_trace(begin_trace),
    .break_force(break_force), .break_tag(break_tag),
    .mcu_reset_req(mcu_reset_req), .armed_flag(armed_flag));
  dbg_checker i_dbg_checker (.pclk(pclk), .presetn(presetn),
    .idx(link.idx), .wdata(link.wdata), .wr(link.wr), .rd(link.rd),
    .serial(link.serial), .rdata(link.rdata), .ack(link.ack),
    .trigger_mode_field(trigger_mode_field), .armed_flag(armed_flag),
    .break_force(break_force), .break_tag(break_tag),
    .mcu_reset_req(mcu_reset_req));
  // ==========================================================
  // Clock, pulse counters, watchdog
  initial begin
    pclk = 1'b0;
    forever #50 pclk = ~pclk;
  end
  always @(posedge pclk) begin
    if (mcu_reset_req === 1'b1) n_rst <= n_rst + 8'h01;
    if (break_tag === 1'b1) n_tag <= n_tag + 8'h01;
    if (break_force === 1'b1) n_force <= n_force + 8'h01;
  end
  initial begin
    repeat (20000) @(posedge pclk);
    n_fail++;
    end_sim;
  end
  // ==========================================================
  // Tasks
  task end_sim;
    $display("checks %0d mismatches %0d", checked, n_fail);
    if (n_fail == 0 && checked > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  task chk(input string n, input logic [7:0] x, input logic [7:0] s);
    checked++;
    if (s !== x) begin
      n_fail++;
      $display("wrong value %s exp %h got %h", n, x, s);
    end
  endtask
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d,
      output logic [31:0] o, output logic err);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    o = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  // Polls status so a command never lands while the link is busy
  task cmd(input logic s, input logic w, input logic [3:0] i,
      input logic [7:0] d, output logic [7:0] o);
    apb(1'b1, 12'h000, {14'h0, s, w, 4'h0, i, d}, r, e);
    do apb(1'b0, 12'h004, 32'h0, r, e); while (r[0] !== 1'b0);
    o = r[15:8];
  endtask
  task rdc(input logic [3:0] i, input logic [7:0] x, input string n);
    cmd(1'b0, 1'b0, i, 8'h00, q);
    chk(n, x, q);
  endtask
  task wrc(input logic s, input logic [3:0] i, input logic [7:0] d);
    cmd(s, 1'b1, i, d, q);
  endtask
  task cpu(input logic [15:0] a, input logic rw, input logic op,
      input logic [7:0] d);
    @(posedge pclk);
    cpu_valid <= 1'b1;
    cpu_addr <= a;
    cpu_read <= rw;
    cpu_opfetch <= op;
    cpu_data <= d;
    @(posedge pclk);
    cpu_valid <= 1'b0;
  endtask
  // ==========================================================
  // Tests
  initial begin
    {presetn, psel, penable, pwrite, paddr, pwdata} = '0;
    {cpu_valid, cpu_read, cpu_opfetch, cpu_addr, cpu_data} = '0;
    {secure, begin_trace, trigger_mode_field} = '0;
    {n_rst, n_tag, n_force, n_fail, checked} = '0;
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
    for (int i = 0; i < 4; i++) begin
      rdc(i[3:0], 8'h00, "cmp reset");
      wrc(1'b0, i[3:0], cv[i]);
      rdc(i[3:0], cv[i], "cmp byte");
    end
    apb(1'b0, 12'h008, 32'h0, r, e);
    chk("unmapped err", 8'h01, {7'h0, e});
    chk("unmapped data", 8'h00, r[7:0]);
    wrc(1'b0, 4'h9, 8'h01);
    rdc(4'h9, 8'h00, "reset reg");
    chk("user reset", 8'h00, n_rst);
    wrc(1'b1, 4'h9, 8'h01);
    chk("serial reset", 8'h01, n_rst);
    secure <= 1'b1;
    wrc(1'b0, 4'h6, 8'h80);
    rdc(4'h6, 8'h00, "secure enable");
    secure <= 1'b0;
    trigger_mode_field <= 4'h3;
    begin_trace <= 1'b1;
    wrc(1'b0, 4'h6, 8'hf3);
    rdc(4'h6, 8'hf3, "control armed");
    chk("armed", 8'h01, {7'h0, armed_flag});
    wrc(1'b0, 4'h0, 8'hff);
    rdc(4'h0, 8'h20, "cmp locked");
    rdc(4'h5, 8'h00, "armed read");
    cpu(16'h3050, 1'b0, 1'b0, 8'hee);
    cpu(16'h3051, 1'b1, 1'b0, 8'hee);
    for (int k = 0; k < 8; k++) cpu(16'h3050, 1'b1, 1'b0, 8'ha0 + k[7:0]);
    repeat (2) @(posedge pclk);
    chk("tag breaks", 8'h01, n_tag);
    chk("run end", 8'h00, {7'h0, armed_flag});
    for (int k = 0; k < 8; k++) begin
      rdc(4'h4, 8'h00, "event high");
      rdc(4'h5, 8'ha0 + k[7:0], "event byte");
    end
    trigger_mode_field <= 4'h0;
    begin_trace <= 1'b0;
    wrc(1'b0, 4'h6, 8'hd4);
    cpu(16'h2040, 1'b1, 1'b0, 8'h00);
    chk("read no trig", 8'h01, {7'h0, armed_flag});
    cpu(16'h2040, 1'b0, 1'b0, 8'h00);
    repeat (2) @(posedge pclk);
    chk("force breaks", 8'h01, n_force);
    chk("tag kept", 8'h01, n_tag);
    chk("end trace", 8'h00, {7'h0, armed_flag});
    cpu(16'h12ab, 1'b1, 1'b1, 8'h00);
    cmd(1'b0, 1'b0, 4'h5, 8'h00, q);
    cpu(16'h3456, 1'b1, 1'b1, 8'h00);
    repeat (7) cmd(1'b0, 1'b0, 4'h5, 8'h00, q);
    rdc(4'h4, 8'h12, "profile high");
    rdc(4'h5, 8'hab, "profile low");
    rdc(4'h5, 8'h56, "profile next");
    trigger_mode_field <= 4'h4;
    rdc(4'h4, 8'h00, "mode4 high");
    trigger_mode_field <= 4'h0;
    rdc(4'h4, 8'h34, "high kept");
    end_sim;
  end
endmodule // debug_compare_trace_regs_tb
